// ===== hw/lrs_map.vh
// register offsets, field positions and reset values of the receive status group
`ifndef LRS_MAP_VH
`define LRS_MAP_VH
// register indices; byte address is four times the index
`define LRS_IDX_FREQ_INT 8'h4f
`define LRS_IDX_FREQ_FRAC 8'h50
`define LRS_IDX_ALARM 8'h51
`define LRS_IDX_VOLT 8'h52
`define LRS_IDX_TEMP 8'h53
`define LRS_IDX_CSI 8'h54
`define LRS_IDX_PAR_HI 8'h55
`define LRS_IDX_PAR_LO 8'h56
`define LRS_IDX_BIST 8'h57
`define LRS_IDX_IRQ_STAT 8'h60
`define LRS_IDX_IRQ_CLR 8'h61
`define LRS_IDX_IRQ_EN 8'h62
`define LRS_IDX_PAR_THOLD 8'h63
`define LRS_IDX_PAR_STS 8'h64
// field layouts
`define LRS_ALARM_W 6
`define LRS_VOLT_W 3
`define LRS_TEMP_W 3
`define LRS_CSI_W 5
`define LRS_VOLT_A_LSB 0
`define LRS_VOLT_B_LSB 4
// interrupt status bits
`define LRS_IRQ_W 3
`define LRS_IRQ_PAR 0
`define LRS_IRQ_ALARM 1
`define LRS_IRQ_CSI 2
// reset values, count increment and saturation limit
`define LRS_RST_BYTE 8'h00
`define LRS_RST_CNT 16'h0000
`define LRS_RST_THOLD 16'h0000
`define LRS_RST_IRQ 3'h0
`define LRS_CNT_MAX 16'hffff
`define LRS_CNT_ONE 16'h0001
`endif

// ===== hw/lrs_sync2.v
// two-flop synchroniser for a W-bit level from outside the clock domain
`timescale 1ns/1ps
module lrs_sync2 #(
  parameter W = 1
) (
  ref_clk,
  rst,
  din,
  dout
);
  input wire ref_clk;
  input wire rst;
  input wire [W-1:0] din;
  output reg [W-1:0] dout;
  reg [W-1:0] meta_r;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// ===== hw/lrs_rise.v
// rising-edge pulse from an already synchronised level
`timescale 1ns/1ps
module lrs_rise (
  ref_clk,
  rst,
  lvl,
  pulse
);
  input wire ref_clk;
  input wire rst;
  input wire lvl;
  output wire pulse;
  reg prev_r;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prev_r <= 1'b0;
    else
      prev_r <= lvl;
  end
  assign pulse = lvl & ~prev_r;
endmodule

// ===== hw/lrs_link_rx_status.v
// receive-port status, mirrored remote sensor fields and error counters
`timescale 1ns/1ps
`include "lrs_map.vh"
module lrs_link_rx_status (
  ref_clk,
  rst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  freqIntegerIn,
  freqFractionIn,
  remoteLoad,
  remoteAlarmIn,
  remoteVoltBIn,
  remoteVoltAIn,
  remoteTempIn,
  remoteCsiIn,
  parityErrPulse,
  lockDetect,
  selftestErrIn,
  parityErrFlag,
  irq
);
  input wire ref_clk;
  input wire rst;
  input wire [9:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire [7:0] freqIntegerIn;
  input wire [7:0] freqFractionIn;
  input wire remoteLoad;
  input wire [5:0] remoteAlarmIn;
  input wire [2:0] remoteVoltBIn;
  input wire [2:0] remoteVoltAIn;
  input wire [2:0] remoteTempIn;
  input wire [4:0] remoteCsiIn;
  input wire parityErrPulse;
  input wire lockDetect;
  input wire [7:0] selftestErrIn;
  output reg parityErrFlag;
  output reg irq;

  // ==========================================================
  // input synchronisation
  // ==========================================================
  // the receiver front end runs on its own recovered clock, so every level is resynced
  wire [7:0] freqIntS;
  wire [7:0] freqFracS;
  wire [7:0] bistS;
  wire [5:0] alarmS;
  wire [2:0] voltBS;
  wire [2:0] voltAS;
  wire [2:0] tempS;
  wire [4:0] csiS;
  wire loadS;
  wire parS;
  wire lockS;
  wire loadRise;
  wire parRise;
  wire lockRise;

  lrs_sync2 #(.W(8)) uSyncFi (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(freqIntegerIn),
    .dout(freqIntS)
  );
  lrs_sync2 #(.W(8)) uSyncFf (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(freqFractionIn),
    .dout(freqFracS)
  );
  lrs_sync2 #(.W(8)) uSyncBi (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(selftestErrIn),
    .dout(bistS)
  );
  // the remote fields are qualified by the load strobe, so a bitwise sync is enough
  lrs_sync2 #(.W(20)) uSyncRm (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({remoteAlarmIn, remoteVoltBIn, remoteVoltAIn, remoteTempIn, remoteCsiIn}),
    .dout({alarmS, voltBS, voltAS, tempS, csiS})
  );
  lrs_sync2 #(.W(3)) uSyncEv (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({remoteLoad, parityErrPulse, lockDetect}),
    .dout({loadS, parS, lockS})
  );

  // edge detectors start low: a strobe pin idling high would give one event after reset
  lrs_rise uRiseLd (
    .ref_clk(ref_clk),
    .rst(rst),
    .lvl(loadS),
    .pulse(loadRise)
  );
  lrs_rise uRisePar (
    .ref_clk(ref_clk),
    .rst(rst),
    .lvl(parS),
    .pulse(parRise)
  );
  lrs_rise uRiseLk (
    .ref_clk(ref_clk),
    .rst(rst),
    .lvl(lockS),
    .pulse(lockRise)
  );

  // ==========================================================
  // measured and mirrored registers
  // ==========================================================
  reg [7:0] freqInt_r;
  reg [7:0] freqFrac_r;
  reg [7:0] bist_r;
  reg [7:0] freqIntPrev_r;
  reg [7:0] freqFracPrev_r;
  reg [7:0] bistPrev_r;
  reg [5:0] alarm_r;
  reg [2:0] voltB_r;
  reg [2:0] voltA_r;
  reg [2:0] temp_r;
  reg [4:0] csi_r;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      freqInt_r <= `LRS_RST_BYTE;
      freqFrac_r <= `LRS_RST_BYTE;
      bist_r <= `LRS_RST_BYTE;
      freqIntPrev_r <= `LRS_RST_BYTE;
      freqFracPrev_r <= `LRS_RST_BYTE;
      bistPrev_r <= `LRS_RST_BYTE;
      alarm_r <= {`LRS_ALARM_W{1'b0}};
      voltB_r <= {`LRS_VOLT_W{1'b0}};
      voltA_r <= {`LRS_VOLT_W{1'b0}};
      temp_r <= {`LRS_TEMP_W{1'b0}};
      csi_r <= {`LRS_CSI_W{1'b0}};
    end
    else
    begin
      // these words have no strobe and may be caught mid-change bit by bit,
      // so a value is taken only once two successive samples agree
      freqIntPrev_r <= freqIntS;
      freqFracPrev_r <= freqFracS;
      bistPrev_r <= bistS;
      if (freqIntS == freqIntPrev_r)
        freqInt_r <= freqIntS;
      if (freqFracS == freqFracPrev_r)
        freqFrac_r <= freqFracS;
      if (bistS == bistPrev_r)
        bist_r <= bistS;
      // the remote frame has settled by the time its load strobe has crossed over
      if (loadRise)
      begin
        alarm_r <= alarmS;
        voltB_r <= voltBS;
        voltA_r <= voltAS;
        temp_r <= tempS;
        csi_r <= csiS;
      end
    end
  end

  // ==========================================================
  // bus decode
  // ==========================================================
  // one wait state: the request is answered on the second edge it is seen
  wire [7:0] regIdx;
  wire busReq;
  wire rdCap;
  wire wrTake;
  wire clrWr;
  wire enWr;
  wire tholdWr;
  assign regIdx = avs_address[9:2];
  assign busReq = avs_read | avs_write;
  // read data is snapshot on the edge the request is first seen
  assign rdCap = avs_read & avs_waitrequest;
  assign wrTake = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign clrWr = wrTake & (regIdx == `LRS_IDX_IRQ_CLR);
  assign enWr = wrTake & (regIdx == `LRS_IDX_IRQ_EN);
  // the threshold has its own byte lanes, so it does not need lane 0
  assign tholdWr = avs_write & ~avs_waitrequest & (regIdx == `LRS_IDX_PAR_THOLD);

  // the count clears on the snapshot edge itself: an error arriving between
  // snapshot and answer would otherwise be dropped without ever being read
  wire rdLo;
  assign rdLo = rdCap & (regIdx == `LRS_IDX_PAR_LO);

  // ==========================================================
  // parity counter, threshold and flag
  // ==========================================================
  reg [15:0] parCnt_r;
  reg [15:0] parCnt_nxt;
  reg [15:0] thold_r;

  always @*
  begin
    parCnt_nxt = parCnt_r;
    if (lockRise | rdLo)
      parCnt_nxt = `LRS_RST_CNT;
    // an error in the clearing cycle counts as the first of the new run
    if (parRise)
    begin
      if (lockRise | rdLo)
        parCnt_nxt = `LRS_CNT_ONE;
      else if (parCnt_r != `LRS_CNT_MAX)
        // saturate so a flood of errors never wraps round to a small count
        parCnt_nxt = parCnt_r + `LRS_CNT_ONE;
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      parCnt_r <= `LRS_RST_CNT;
      parityErrFlag <= 1'b0;
    end
    else
    begin
      parCnt_r <= parCnt_nxt;
      parityErrFlag <= (parCnt_nxt > thold_r);
    end
  end

  // ==========================================================
  // interrupt status, clear, enable and threshold
  // ==========================================================
  reg [2:0] irqStat_r;
  reg [2:0] irqEn_r;
  reg [2:0] irqEvt;
  reg [2:0] irqClr;

  always @*
  begin
    irqEvt = `LRS_RST_IRQ;
    irqEvt[`LRS_IRQ_PAR] = (parCnt_nxt > thold_r) & ~parityErrFlag;
    irqEvt[`LRS_IRQ_ALARM] = loadRise & (alarmS != alarm_r);
    irqEvt[`LRS_IRQ_CSI] = loadRise & (csiS != csi_r);
    irqClr = `LRS_RST_IRQ;
    if (clrWr)
      irqClr = avs_writedata[2:0];
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irqStat_r <= `LRS_RST_IRQ;
      irqEn_r <= `LRS_RST_IRQ;
      thold_r <= `LRS_RST_THOLD;
      irq <= 1'b0;
    end
    else
    begin
      // a new event wins over a clear written in the same cycle
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
      // built from the stored enable, so irq follows an enable write one cycle late
      irq <= |(((irqStat_r & ~irqClr) | irqEvt) & irqEn_r);
      if (enWr)
        irqEn_r <= avs_writedata[2:0];
      if (tholdWr)
      begin
        if (avs_byteenable[0])
          thold_r[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1])
          thold_r[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // ==========================================================
  // read mux and waitrequest
  // ==========================================================
  // reserved bits read zero because every case starts from an all-zero word
  reg [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h00000000;
    case (regIdx)
      `LRS_IDX_FREQ_INT: rdMux[7:0] = freqInt_r;
      `LRS_IDX_FREQ_FRAC: rdMux[7:0] = freqFrac_r;
      `LRS_IDX_ALARM: rdMux[5:0] = alarm_r;
      `LRS_IDX_VOLT:
      begin
        rdMux[`LRS_VOLT_B_LSB+`LRS_VOLT_W-1:`LRS_VOLT_B_LSB] = voltB_r;
        rdMux[`LRS_VOLT_A_LSB+`LRS_VOLT_W-1:`LRS_VOLT_A_LSB] = voltA_r;
      end
      `LRS_IDX_TEMP: rdMux[2:0] = temp_r;
      `LRS_IDX_CSI: rdMux[4:0] = csi_r;
      `LRS_IDX_PAR_HI: rdMux[7:0] = parCnt_r[15:8];
      `LRS_IDX_PAR_LO: rdMux[7:0] = parCnt_r[7:0];
      `LRS_IDX_BIST: rdMux[7:0] = bist_r;
      `LRS_IDX_IRQ_STAT: rdMux[2:0] = irqStat_r;
      `LRS_IDX_IRQ_EN: rdMux[2:0] = irqEn_r;
      `LRS_IDX_PAR_THOLD: rdMux[15:0] = thold_r;
      `LRS_IDX_PAR_STS: rdMux[0] = parityErrFlag;
      default: rdMux = 32'h00000000;
    endcase
  end

  // writes to status, count and mirror registers have no path to them
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= ~(busReq & avs_waitrequest);
      if (rdCap)
        avs_readdata <= rdMux;
    end
  end
endmodule

// ===== bench/lrs_rx_chk_sva.sv
// checker of bus timing, reserved bits and parity flag of the status group
`timescale 1ns/1ps
module lrs_rx_chk (
  input wire ref_clk,
  input wire rst,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire parityErrFlag
);
  // ==========
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rdDone = avs_read && !avs_waitrequest;
  wire [7:0] idx = avs_address[9:2];
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer late");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  chk_rd_hold: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved");
  chk_rd_unmapped: assert property (rdDone && idx == 8'h70 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_alarm_rsvd: assert property (rdDone && idx == 8'h51 |-> avs_readdata[31:6] == 0)
    else $error("alarm reserved set");
  chk_volt_rsvd: assert property (rdDone && idx == 8'h52
    |-> !avs_readdata[7] && !avs_readdata[3]) else $error("volt reserved set");
  chk_temp_rsvd: assert property (rdDone && idx == 8'h53 |-> avs_readdata[31:3] == 0)
    else $error("temp reserved set");
  chk_csi_rsvd: assert property (rdDone && idx == 8'h54 |-> avs_readdata[31:5] == 0)
    else $error("csi reserved set");
  chk_flag_clear: assert property (rdDone && idx == 8'h56 |-> ##[1:3] !parityErrFlag)
    else $error("flag kept after clear");
  cover property (rdDone && idx == 8'h56);
  cover property ($rose(parityErrFlag));
  cover property (avs_write && !avs_waitrequest);
endmodule

bind lrs_link_rx_status lrs_rx_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .parityErrFlag(parityErrFlag));

// ===== bench/lrs_ser_model.sv
// remote serializer: status loads, parity errors and lock events
`timescale 1ns/1ps
module lrs_ser_model (
  input wire ref_clk,
  output reg remoteLoad = 1'b0,
  output reg [19:0] fields = 20'h0,
  output reg parityErrPulse = 1'b0,
  output reg lockDetect = 1'b0
);
  // fields hold round the load edge, then flip so a late sample shows
  task send(input [19:0] f);
  begin
    @(posedge ref_clk);
    fields <= f;
    repeat (2) @(posedge ref_clk);
    remoteLoad <= 1'b1;
    repeat (4) @(posedge ref_clk);
    remoteLoad <= 1'b0;
    repeat (4) @(posedge ref_clk);
    fields <= ~f;
  end
  endtask
  task par(input integer n);
    integer k;
  begin
    for (k = 0; k < n; k = k + 1)
    begin
      @(posedge ref_clk);
      parityErrPulse <= 1'b1;
      repeat (2) @(posedge ref_clk);
      parityErrPulse <= 1'b0;
      @(posedge ref_clk);
    end
  end
  endtask
  task lock;
  begin
    @(posedge ref_clk);
    lockDetect <= 1'b1;
    repeat (3) @(posedge ref_clk);
    lockDetect <= 1'b0;
  end
  endtask
endmodule

// ===== bench/testbench.sv
// testbench of the receive status group
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [9:0] adr = 10'h0;
  reg rdEn = 1'b0;
  reg wrEn = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [3:0] be = 4'hf;
  reg [23:0] lvl = 24'h0;
  wire [31:0] rdat;
  wire waitReq, flag, irq, load, pe, lk;
  wire [19:0] f;
  integer errorCnt = 0;
  integer compares = 0;
  integer i;
  reg [31:0] q;
  reg [19:0] v;
  always #2.5 ref_clk = ~ref_clk;
  lrs_link_rx_status DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(adr),
    .avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(waitReq), .freqIntegerIn(lvl[23:16]),
    .freqFractionIn(lvl[15:8]), .remoteLoad(load), .remoteAlarmIn(f[19:14]),
    .remoteVoltBIn(f[13:11]), .remoteVoltAIn(f[10:8]), .remoteTempIn(f[7:5]),
    .remoteCsiIn(f[4:0]), .parityErrPulse(pe), .lockDetect(lk),
    .selftestErrIn(lvl[7:0]), .parityErrFlag(flag), .irq(irq));
  lrs_ser_model ser (.ref_clk(ref_clk), .remoteLoad(load), .fields(f),
    .parityErrPulse(pe), .lockDetect(lk));
  // ==========
  // tasks
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      errorCnt = errorCnt + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task acc(input w, input [7:0] idx, input [31:0] d);
    integer n;
  begin
    adr <= {idx, 2'b00};
    rdEn <= !w;
    wrEn <= w;
    wd <= d;
    n = 0;
    @(posedge ref_clk);
    while (waitReq !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    if (n == 50) errorCnt = errorCnt + 1;
    q = rdat;
    rdEn <= 1'b0;
    wrEn <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task rd(input [7:0] idx, input [31:0] e);
  begin
    acc(1'b0, idx, 32'h0);
    chk(q, e);
  end
  endtask
  task finishTest;
  begin
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errorCnt = errorCnt + 1;
    finishTest;
  end
  // ==========
  // tests
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 8'h4f; i <= 8'h57; i = i + 1)
      rd(i, 32'h0);
    lvl <= 24'ha53c7e;
    repeat (6) @(posedge ref_clk);
    for (i = 8'h4f; i <= 8'h57; i = i + 1)
      acc(1'b1, i, 32'hff);
    rd(8'h4f, 32'ha5);
    rd(8'h50, 32'h3c);
    rd(8'h57, 32'h7e);
    rd(8'h51, 32'h0);
    rd(8'h70, 32'h0);
    $display("test levels done");
    for (i = 0; i < 2; i = i + 1)
    begin
      v = i ? 20'h5552a : 20'haaad5;
      ser.send(v);
      repeat (4) @(posedge ref_clk);
      rd(8'h51, {26'h0, v[19:14]});
      rd(8'h52, {25'h0, v[13:11], 1'b0, v[10:8]});
      rd(8'h53, {29'h0, v[7:5]});
      rd(8'h54, {27'h0, v[4:0]});
    end
    $display("test remote done");
    // lane 1 is masked off, so only the low threshold byte may land
    be <= 4'h1;
    acc(1'b1, 8'h63, 32'hff02);
    be <= 4'hf;
    rd(8'h63, 32'h2);
    ser.par(2);
    repeat (6) @(posedge ref_clk);
    rd(8'h64, 32'h0);
    ser.par(256);
    repeat (6) @(posedge ref_clk);
    rd(8'h64, 32'h1);
    chk(flag, 1'b1);
    rd(8'h60, 32'h7);
    chk(irq, 1'b0);
    acc(1'b1, 8'h62, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    rd(8'h62, 32'h1);
    acc(1'b1, 8'h61, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    rd(8'h60, 32'h6);
    // errors stopped before the count is read
    rd(8'h55, 32'h1);
    rd(8'h55, 32'h1);
    rd(8'h56, 32'h2);
    rd(8'h55, 32'h0);
    rd(8'h64, 32'h0);
    chk(flag, 1'b0);
    ser.par(3);
    repeat (6) @(posedge ref_clk);
    rd(8'h56, 32'h3);
    ser.par(2);
    ser.lock;
    repeat (6) @(posedge ref_clk);
    rd(8'h56, 32'h0);
    $display("test parity done");
    finishTest;
  end
endmodule
